// ===== hw/buzzer_params.svh
`ifndef BUZZER_PARAMS_SVH
`define BUZZER_PARAMS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define REG_AW            8
`define CTRL_ADDR         8'h00
`define SOUND_ADDR        8'h04
`define STATUS_ADDR       8'h08
`define CTRL_RESET        8'h00
`define SOUND_RESET       8'h00
`define STATUS_W          8

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define OSC_HZ            32768
`define TICK_HZ           256
`define TICK_DIV          (`OSC_HZ / `TICK_HZ)
`define TICK_DIV_W        7
`define TICK_NS           (1000000000 / `TICK_HZ)
`define STEP_FAST_NS      62500000
`define STEP_SLOW_NS      125000000
`define SHOT_SHORT_NS     31250000
`define SHOT_LONG_NS      125000000
`define TICK_CNT_W        6
`define STEP_FAST_TICKS   (`STEP_FAST_NS / `TICK_NS)
`define STEP_SLOW_TICKS   (`STEP_SLOW_NS / `TICK_NS)
`define SHOT_SHORT_TICKS  (`SHOT_SHORT_NS / `TICK_NS)
`define SHOT_LONG_TICKS   (`SHOT_LONG_NS / `TICK_NS)

// ---------------------------------------------------------------
// tone shape
// ---------------------------------------------------------------
`define DEN_16            5'h10
`define DEN_20            5'h14
`define DEN_24            5'h18
`define DEN_28            5'h1c
`define HIGH_NARROW       5'h08
`define HIGH_WIDE         5'h0c
`define LEVEL_MAX         3'h0
`define LEVEL_MIN         3'h7

`endif

// ===== hw/buzzer_pkg.sv
package buzzer_pkg;

  typedef logic [2:0] level_t;
  typedef logic [4:0] slot_t;

  typedef struct packed {
    logic   spare;
    logic   oneshot_force_stop;
    logic   oneshot_trigger_busy;
    logic   oneshot_length_select;
    logic   decay_step_select;
    logic   decay_restart;
    logic   decay_enable;
    logic   tone_continuous_enable;
  } ctrl_s;

  typedef struct packed {
    logic   spare_hi;
    level_t tone_level_select;
    logic   spare_lo;
    level_t tone_freq_select;
  } sound_s;

  typedef enum logic [1:0] {
    SHOT_IDLE  = 2'b00,
    SHOT_ALIGN = 2'b01,
    SHOT_PLAY  = 2'b10
  } oneshot_e;

endpackage

// ===== hw/tone_wave.sv
`timescale 1ns/1ps
`default_nettype none
`include "buzzer_params.svh"

module tone_wave (
  input  wire logic               clock,
  input  wire logic               resetn,
  input  wire logic               osc_rise,
  input  wire logic               osc_fall,
  input  wire logic               active,
  input  wire buzzer_pkg::level_t freq,
  input  wire buzzer_pkg::level_t level,
  output logic                    wave
);

  function automatic buzzer_pkg::slot_t den_of(input buzzer_pkg::level_t f);
    if (f[1:0] == 2'h0) den_of = `DEN_16;
    else if (f[1:0] == 2'h1) den_of = `DEN_20;
    else if (f[1:0] == 2'h2) den_of = `DEN_24;
    else den_of = `DEN_28;
  endfunction

  function automatic buzzer_pkg::slot_t high_of(input buzzer_pkg::level_t f,
                                                input buzzer_pkg::level_t l);
    high_of = (f[1] ? `HIGH_WIDE : `HIGH_NARROW) - {2'h0, l};
  endfunction

  buzzer_pkg::slot_t  slot_cnt;
  buzzer_pkg::level_t cur_freq;
  buzzer_pkg::level_t cur_level;
  logic               slot;
  logic               last;

  // low four codes slot on both oscillator edges, high four on rising only
  assign slot = cur_freq[2] ? osc_rise : (osc_rise | osc_fall);
  assign last = slot_cnt == den_of(cur_freq) - 5'h01;

  // settings are taken on every clock while inactive, and otherwise only at a period boundary
  always_ff @(posedge clock) begin
    if (!resetn) begin
      slot_cnt  <= 5'h00;
      cur_freq  <= 3'h0;
      cur_level <= `LEVEL_MAX;
    end else if (!active) begin
      slot_cnt  <= 5'h00;
      cur_freq  <= freq;
      cur_level <= level;
    end else if (slot) begin
      if (last) begin
        slot_cnt  <= 5'h00;
        cur_freq  <= freq;
        cur_level <= level;
      end else begin
        slot_cnt <= slot_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || !active) wave <= 1'b0;
    else wave <= slot_cnt < high_of(cur_freq, cur_level);
  end

endmodule
`default_nettype wire

// ===== hw/decay_envelope.sv
`timescale 1ns/1ps
`default_nettype none
`include "buzzer_params.svh"

module decay_envelope (
  input  wire logic          clock,
  input  wire logic          resetn,
  input  wire logic          tick,
  input  wire logic          run,
  input  wire logic          restart,
  input  wire logic          slow,
  output buzzer_pkg::level_t level
);

  logic [`TICK_CNT_W-1:0] step_cnt;
  logic [`TICK_CNT_W-1:0] step_last;

  assign step_last = slow ? `TICK_CNT_W'(`STEP_SLOW_TICKS - 1)
                          : `TICK_CNT_W'(`STEP_FAST_TICKS - 1);

  always_ff @(posedge clock) begin
    if (!resetn || !run || restart) begin
      level    <= `LEVEL_MAX;
      step_cnt <= '0;
    end else if (tick) begin
      if (step_cnt >= step_last) begin
        step_cnt <= '0;
        if (level != `LEVEL_MIN) level <= level + 3'h1;
      end else begin
        step_cnt <= step_cnt + `TICK_CNT_W'(1);
      end
    end
  end

endmodule
`default_nettype wire

// ===== hw/buzzer_sound_generator.sv
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "buzzer_params.svh"

module buzzer_sound_generator #(
  parameter bit INVERTED_OUTPUT = 1'b1
) (
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic [`REG_AW-1:0]  paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                low_speed_oscillator,
  input  wire logic                tone_pin_port_data,
  output logic                     tone_pin,
  output logic                     tone_inverted_pin
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  function automatic logic is_mapped(input logic [`REG_AW-1:0] a);
    if (a == `CTRL_ADDR) is_mapped = 1'b1;
    else if (a == `SOUND_ADDR) is_mapped = 1'b1;
    else if (a == `STATUS_ADDR) is_mapped = 1'b1;
    else is_mapped = 1'b0;
  endfunction

  logic access;
  logic wr_ctrl;
  logic wr_sound;

  assign access   = psel && penable;
  assign pready   = 1'b1;
  assign pslverr  = access && !is_mapped(paddr);
  assign wr_ctrl  = access && pwrite && (paddr == `CTRL_ADDR);
  assign wr_sound = access && pwrite && (paddr == `SOUND_ADDR);

  buzzer_pkg::ctrl_s  wdata_ctrl;
  buzzer_pkg::sound_s wdata_sound;

  assign wdata_ctrl  = buzzer_pkg::ctrl_s'(pwdata[7:0]);
  assign wdata_sound = buzzer_pkg::sound_s'(pwdata[7:0]);

  // ---------------------------------------------------------------
  // write strobes
  // ---------------------------------------------------------------
  logic trig_req;
  logic stop_req;
  logic restart_req;

  assign stop_req    = wr_ctrl && wdata_ctrl.oneshot_force_stop;
  assign restart_req = wr_ctrl && wdata_ctrl.decay_restart;

  // ---------------------------------------------------------------
  // software settings
  // ---------------------------------------------------------------
  logic               continuous_on;
  logic               decay_on;
  logic               step_slow;
  logic               shot_long;
  buzzer_pkg::level_t freq_sel;
  buzzer_pkg::level_t level_sel;

  // trigger only counts while the continuous tone is off
  assign trig_req = wr_ctrl && wdata_ctrl.oneshot_trigger_busy
                    && !continuous_on;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      continuous_on <= 1'b0;
      step_slow     <= 1'b0;
      shot_long     <= 1'b0;
    end else if (wr_ctrl) begin
      continuous_on <= wdata_ctrl.tone_continuous_enable;
      step_slow     <= wdata_ctrl.decay_step_select;
      shot_long     <= wdata_ctrl.oneshot_length_select;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) decay_on <= 1'b0;
    else if (trig_req) decay_on <= 1'b0;
    else if (wr_ctrl) decay_on <= wdata_ctrl.decay_enable;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      freq_sel  <= 3'h0;
      level_sel <= `LEVEL_MAX;
    end else if (wr_sound) begin
      freq_sel  <= wdata_sound.tone_freq_select;
      level_sel <= wdata_sound.tone_level_select;
    end
  end

  // ---------------------------------------------------------------
  // oscillator edges and 256 Hz tick
  // ---------------------------------------------------------------
  logic                   osc_prev;
  logic                   osc_rise;
  logic                   osc_fall;
  logic [`TICK_DIV_W-1:0] tick_div;
  logic                   tick;

  always_ff @(posedge clock) begin
    if (!resetn) osc_prev <= 1'b0;
    else osc_prev <= low_speed_oscillator;
  end

  assign osc_rise = low_speed_oscillator && !osc_prev;
  assign osc_fall = !low_speed_oscillator && osc_prev;

  always_ff @(posedge clock) begin
    if (!resetn) tick_div <= '0;
    else if (osc_rise) tick_div <= tick_div + `TICK_DIV_W'(1);
  end

  assign tick = osc_rise && (tick_div == `TICK_DIV_W'(`TICK_DIV - 1));

  // ---------------------------------------------------------------
  // one-shot sequencer
  // ---------------------------------------------------------------
  buzzer_pkg::oneshot_e   shot_state;
  buzzer_pkg::oneshot_e   next_shot_state;
  logic [`TICK_CNT_W-1:0] shot_cnt;
  logic [`TICK_CNT_W-1:0] shot_last;
  logic                   shot_busy;
  logic                   shot_done;

  assign shot_last = shot_long ? `TICK_CNT_W'(`SHOT_LONG_TICKS - 1)
                               : `TICK_CNT_W'(`SHOT_SHORT_TICKS - 1);
  assign shot_done = tick && (shot_cnt >= shot_last);

  always_comb begin
    next_shot_state = shot_state;
    case (shot_state)
      buzzer_pkg::SHOT_IDLE: begin
        if (trig_req) next_shot_state = buzzer_pkg::SHOT_ALIGN;
      end
      buzzer_pkg::SHOT_ALIGN: begin
        if (tick) next_shot_state = buzzer_pkg::SHOT_PLAY;
      end
      buzzer_pkg::SHOT_PLAY: begin
        if (shot_done && !trig_req) begin
          next_shot_state = buzzer_pkg::SHOT_IDLE;
        end
      end
      default: next_shot_state = buzzer_pkg::SHOT_IDLE;
    endcase
    // a fresh trigger wins over expiry, a force stop over everything
    if (stop_req) next_shot_state = buzzer_pkg::SHOT_IDLE;
  end

  always_ff @(posedge clock) begin
    if (!resetn) shot_state <= buzzer_pkg::SHOT_IDLE;
    else shot_state <= next_shot_state;
  end

  // duration counts 256 Hz ticks from the latest trigger
  always_ff @(posedge clock) begin
    if (!resetn) shot_cnt <= '0;
    else if (trig_req) shot_cnt <= '0;
    else if (shot_state != buzzer_pkg::SHOT_PLAY) shot_cnt <= '0;
    else if (tick) shot_cnt <= shot_cnt + `TICK_CNT_W'(1);
  end

  assign shot_busy = shot_state != buzzer_pkg::SHOT_IDLE;

  // ---------------------------------------------------------------
  // envelope and duty choice
  // ---------------------------------------------------------------
  logic               env_run;
  buzzer_pkg::level_t env_level;
  buzzer_pkg::level_t duty_level;

  assign env_run = continuous_on && decay_on;

  decay_envelope u_envelope (
    .clock   (clock),
    .resetn  (resetn),
    .tick    (tick),
    .run     (env_run),
    .restart (restart_req),
    .slow    (step_slow),
    .level   (env_level)
  );

  assign duty_level = decay_on ? env_level : level_sel;

  // ---------------------------------------------------------------
  // tone generation
  // ---------------------------------------------------------------
  logic tone_active;
  logic tone_out;

  assign tone_active = continuous_on
                       || (shot_state == buzzer_pkg::SHOT_PLAY);

  tone_wave u_wave (
    .clock    (clock),
    .resetn   (resetn),
    .osc_rise (osc_rise),
    .osc_fall (osc_fall),
    .active   (tone_active),
    .freq     (freq_sel),
    .level    (duty_level),
    .wave     (tone_out)
  );

  // ---------------------------------------------------------------
  // output pins
  // ---------------------------------------------------------------
  // primary pin only shows the tone while its port data bit is low
  always_ff @(posedge clock) begin
    if (!resetn) tone_pin <= 1'b0;
    else tone_pin <= tone_out || tone_pin_port_data;
  end

  // inverted pin idles high; option off parks it high as well
  always_ff @(posedge clock) begin
    if (!resetn) tone_inverted_pin <= 1'b1;
    else if (INVERTED_OUTPUT) tone_inverted_pin <= !tone_out;
    else tone_inverted_pin <= 1'b1;
  end

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  buzzer_pkg::ctrl_s    rd_ctrl;
  buzzer_pkg::sound_s   rd_sound;
  logic [`STATUS_W-1:0] rd_status;

  always_comb begin
    rd_ctrl                        = '0;
    rd_ctrl.tone_continuous_enable = continuous_on;
    rd_ctrl.decay_enable           = decay_on;
    rd_ctrl.decay_step_select      = step_slow;
    rd_ctrl.oneshot_length_select  = shot_long;
    rd_ctrl.oneshot_trigger_busy   = shot_busy;
  end

  always_comb begin
    rd_sound                   = '0;
    rd_sound.tone_freq_select  = freq_sel;
    rd_sound.tone_level_select = level_sel;
  end

  // status: duty level in use, tone running, wave level, sequencer state
  assign rd_status = {shot_state, tone_out, tone_active, 1'b0, duty_level};

  always_comb begin
    prdata = '0;
    if (access && !pwrite) begin
      if (paddr == `CTRL_ADDR) prdata[7:0] = rd_ctrl;
      else if (paddr == `SOUND_ADDR) prdata[7:0] = rd_sound;
      else if (paddr == `STATUS_ADDR) prdata[`STATUS_W-1:0] = rd_status;
      else prdata = '0;
    end
  end

endmodule
`default_nettype wire

// ===== verif/buzzer_sound_generator_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "buzzer_params.svh"
module buzzer_sound_generator_chk #(
  parameter bit INVERTED_OUTPUT = 1'b1
) (
  input wire logic               clock,
  input wire logic               resetn,
  input wire logic [`REG_AW-1:0] paddr,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               low_speed_oscillator,
  input wire logic               tone_pin_port_data,
  input wire logic               tone_pin,
  input wire logic               tone_inverted_pin
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // -------------------------------------------------------------
  // access decode
  // -------------------------------------------------------------
  logic acc;
  logic wr_c;
  logic rd_c;
  logic rd_s;
  logic mapd;
  assign acc  = psel && penable;
  assign wr_c = acc && pwrite && paddr == `CTRL_ADDR;
  assign rd_c = acc && !pwrite && paddr == `CTRL_ADDR;
  assign rd_s = acc && !pwrite && paddr == `STATUS_ADDR;
  assign mapd = paddr inside {`CTRL_ADDR, `SOUND_ADDR, `STATUS_ADDR};
  property p_ready;
    pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err;
    pslverr |-> acc && !mapd;
  endproperty
  a_err: assert property (p_err) else $error("stray pslverr");
  property p_unmap;
    acc && !mapd |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access");
  property p_rdidle;
    !(acc && !pwrite) |-> prdata == 32'h0;
  endproperty
  a_rdidle: assert property (p_rdidle) else $error("prdata not zero");
  property p_trig;
    wr_c && pwdata[5] && !pwdata[6] && !pwdata[0] ##3 rd_c
      |-> prdata[5] && !prdata[1];
  endproperty
  a_trig: assert property (p_trig) else $error("trigger");
  property p_stop;
    wr_c && pwdata[5] && pwdata[6] ##3 rd_c |-> !prdata[5];
  endproperty
  a_stop: assert property (p_stop) else $error("stop lost");
  property p_restart;
    wr_c && pwdata[2:0] == 3'h7 ##3 rd_s |-> prdata[2:0] == `LEVEL_MAX;
  endproperty
  a_restart: assert property (p_restart) else $error("restart");
  property p_inv;
    !tone_pin_port_data && $stable(tone_pin_port_data)
      |-> tone_inverted_pin == (INVERTED_OUTPUT ? !tone_pin : 1'b1);
  endproperty
  a_inv: assert property (p_inv) else $error("inverted pin");
  property p_silent;
    wr_c && pwdata[6] && !pwdata[0] && !tone_pin_port_data
      |-> ##[1:3] (!tone_pin && tone_inverted_pin);
  endproperty
  a_silent: assert property (p_silent) else $error("stop");
endmodule
bind buzzer_sound_generator buzzer_sound_generator_chk #(
  .INVERTED_OUTPUT(INVERTED_OUTPUT)
) chk_i (
  .clock(clock), .resetn(resetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .low_speed_oscillator(low_speed_oscillator),
  .tone_pin_port_data(tone_pin_port_data), .tone_pin(tone_pin),
  .tone_inverted_pin(tone_inverted_pin)
);
`default_nettype wire

// ===== verif/piezo_model.sv
`timescale 1ns/1ps
`default_nettype none
module piezo_model (
  input  wire logic clock,
  input  wire logic tone_pin,
  input  wire logic tone_inverted_pin,
  output int        high_len,
  output int        period_len
);
  // -------------------------------------------------------------
  // transducer across both pins: measures drive in clock cycles
  // -------------------------------------------------------------
  logic drive;
  logic last = 1'b0;
  int   run_h = 0;
  int   run_p = 0;
  assign drive = tone_pin & ~tone_inverted_pin;
  initial high_len = 0;
  initial period_len = 0;
  always @(posedge clock) begin
    if (drive && !last) begin
      period_len <= run_p;
      run_p <= 1;
    end else begin
      run_p <= run_p + 1;
    end
    if (!drive && last) high_len <= run_h;
    run_h <= drive ? run_h + 1 : 0;
    last <= drive;
  end
endmodule
`default_nettype wire

// ===== verif/buzzer_sound_generator_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "buzzer_params.svh"
module buzzer_sound_generator_test;
  logic               clock = 1'b0;
  logic               resetn = 1'b0;
  logic [`REG_AW-1:0] paddr = '0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [31:0]        pwdata = '0;
  logic               osc = 1'b0;
  logic               port_data = 1'b0;
  logic [31:0]        prdata, rd;
  logic               pready, pslverr, tone_pin, tone_inverted_pin, err;
  logic [2:0]         lv;
  logic [1:0]         sp;
  logic [7:0]         sv;
  int                 high_len, period_len, t0;
  int                 cyc = 0;
  int                 error_cnt = 0;
  int                 n_compared = 0;
  int                 exp_q[$];
  always #25 clock = ~clock;
  // oscillator runs fast: one edge per clock
  always @(posedge clock) begin
    osc <= ~osc;
    cyc <= cyc + 1;
  end
  buzzer_sound_generator #(.INVERTED_OUTPUT(1'b1)) buzzer_sound_generator_i (
    .clock(clock), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .low_speed_oscillator(osc),
    .tone_pin_port_data(port_data), .tone_pin(tone_pin),
    .tone_inverted_pin(tone_inverted_pin));
  piezo_model piezo_model_i (.clock(clock), .tone_pin(tone_pin),
    .tone_inverted_pin(tone_inverted_pin), .high_len(high_len),
    .period_len(period_len));
  // -------------------------------------------------------------
  // reference model and bus tasks
  // -------------------------------------------------------------
  function automatic int slot(int f);
    return (f < 4) ? 1 : 2;
  endfunction
  function automatic int e_per(int f);
    return (16 + 4 * (f % 4)) * slot(f);
  endfunction
  function automatic int e_high(int f, int l);
    return (((f % 4) < 2 ? 8 : 12) - l) * slot(f);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask
  task automatic env_at(input int at, input logic [2:0] l);
    while (cyc - t0 < at) @(posedge clock);
    rdm(`STATUS_ADDR, 32'h7, {29'h0, l});
  endtask
  task automatic shot(input logic lng, input int gap, input int nt);
    int n;
    t0 = cyc;
    wr(`CTRL_ADDR, {3'b001, lng, 4'b0010});
    rdm(`CTRL_ADDR, 32'h22, 32'h20);
    n = 0;
    while (tone_pin !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    check(n <= 264, 1'b1);
    while (cyc - t0 < gap) @(posedge clock);
    if (gap > 0) wr(`CTRL_ADDR, {3'b001, lng, 4'b0010});
    do begin
      apb(1'b0, `CTRL_ADDR, 32'h0);
      n = cyc - t0;
    end while (rd[5] === 1'b1 && n < 12000);
    check(n >= gap + (nt - 1) * 256 && n <= gap + (nt + 1) * 256 + 20,
          1'b1);
    wait_clk(4);
    check({tone_pin, tone_inverted_pin}, 2'b01);
  endtask
  task automatic end_test(input string s);
    $display("test %s done, mismatches %0d", s, error_cnt);
  endtask
  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    wait_clk(95000);
    error_cnt++;
    give_verdict();
  end
  initial begin
    void'($urandom(77239));
    wait_clk(8);
    resetn <= 1'b1;
    rdm(`CTRL_ADDR, '1, 32'h0);
    rdm(`SOUND_ADDR, '1, 32'h0);
    rdm(`STATUS_ADDR, '1, 32'h0);
    check({tone_pin, tone_inverted_pin}, 2'b01);
    apb(1'b0, 8'h0c, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    wr(8'h0c, 8'hff);
    rdm(`CTRL_ADDR, '1, 32'h0);
    end_test("reset and map");
    for (int f = 0; f < 8; f++) begin
      lv = 3'($urandom_range(7));
      sp = 2'($urandom);
      sv = {sp[1], lv, sp[0], f[2:0]};
      wr(`SOUND_ADDR, sv);
      rdm(`SOUND_ADDR, '1, {24'h0, sv & 8'h77});
      wr(`CTRL_ADDR, 8'h01);
      exp_q.push_back(e_per(f));
      exp_q.push_back(e_high(f, lv));
      wait_clk(2 * e_per(f) + 80);
      check(period_len, exp_q.pop_front());
      check(high_len, exp_q.pop_front());
    end
    wr(`CTRL_ADDR, 8'h00);
    wait_clk(4);
    check({tone_pin, tone_inverted_pin}, 2'b01);
    port_data <= 1'b1;
    wait_clk(3);
    check(tone_pin, 1'b1);
    port_data <= 1'b0;
    end_test("tone");
    wr(`SOUND_ADDR, 8'h50);
    wr(`CTRL_ADDR, 8'h03);
    t0 = cyc;
    env_at(2048, 3'h0);
    env_at(6144, 3'h1);
    env_at(34816, 3'h7);
    check(high_len, e_high(0, 7));
    wr(`CTRL_ADDR, 8'h07);
    t0 = cyc;
    rdm(`STATUS_ADDR, 32'h7, 32'h0);
    env_at(6144, 3'h1);
    wr(`CTRL_ADDR, 8'h0f);
    t0 = cyc;
    env_at(6144, 3'h0);
    env_at(12288, 3'h1);
    wr(`CTRL_ADDR, 8'h01);
    wait_clk(40);
    rdm(`STATUS_ADDR, 32'h7, 32'h5);
    wr(`CTRL_ADDR, 8'h00);
    end_test("envelope");
    shot(1'b0, 1024, 8);
    shot(1'b1, 0, 32);
    wr(`CTRL_ADDR, 8'h20);
    wait_clk(600);
    wr(`CTRL_ADDR, 8'h40);
    rdm(`CTRL_ADDR, 32'h20, 32'h0);
    check({tone_pin, tone_inverted_pin}, 2'b01);
    wr(`CTRL_ADDR, 8'h60);
    rdm(`CTRL_ADDR, 32'h20, 32'h0);
    wr(`CTRL_ADDR, 8'h01);
    wr(`CTRL_ADDR, 8'h21);
    rdm(`CTRL_ADDR, '1, 32'h1);
    wr(`CTRL_ADDR, 8'h00);
    end_test("one-shot");
    give_verdict();
  end
endmodule
`default_nettype wire
